// ==== logic/pss_pkg.sv ====
// Purpose: Shared constants and types of the power and shutdown supervisor
// Assumes: 20 MHz module clock
// Notes: Times are kept in their own unit; all cycle counts but UV_GAP_CYC derive from them
`default_nettype none
package pss_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned GUARD_S = 120;
  localparam int unsigned CRIT_DELAY_S = 5;
  localparam int unsigned SHUTDOWN_ACTIVE_S = 2;
  localparam int unsigned GUARD_CYC = GUARD_S * CLK_HZ;
  localparam int unsigned CRIT_DELAY_CYC = CRIT_DELAY_S * CLK_HZ;
  localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_ACTIVE_S * CLK_HZ;
  localparam int unsigned UV_REPEAT = 4;
  localparam int unsigned UV_GAP_CYC = 20000000;
  localparam logic [1:0] TEMP_ALERT_PRES_RST = 2'h0;
  localparam logic CRIT_SD_EN_RST = 1'h1;
  localparam logic EXPECT_TR_RST = 1'h1;
  // Temperature level codes, two's complement
  localparam logic [2:0] TEMP_P2 = 3'h2;
  localparam logic [2:0] TEMP_P1 = 3'h1;
  localparam logic [2:0] TEMP_Z0 = 3'h0;
  localparam logic [2:0] TEMP_M1 = 3'h7;
  localparam logic [2:0] TEMP_M2 = 3'h6;
  // Message kinds to the host
  typedef enum logic [2:0] {
    PSS_MSG_NONE = 3'h0,
    PSS_MSG_TEMP = 3'h1,
    PSS_MSG_UNDERV = 3'h2,
    PSS_MSG_OVERV = 3'h3,
    PSS_MSG_SHUTDOWN = 3'h4
  } pss_msg_kind_t;
  typedef struct packed {
    pss_msg_kind_t kind;
    logic [2:0] level;
  } pss_msg_t;
  typedef enum logic [1:0] {
    PSS_INIT = 2'h0,
    PSS_RUN = 2'h1,
    PSS_SHUT = 2'h2,
    PSS_OFF = 2'h3
  } pss_state_t;
  // Configuration held in non-volatile storage
  typedef struct packed {
    logic alert_always;
    logic crit_sd_en;
    logic expect_tr;
  } pss_cfg_t;
endpackage
`default_nettype wire

// ==== logic/pss_supervisor.sv ====
// Purpose: Startup completion, orderly shutdown, temperature and supply alerts, sleep entry
// Assumes: One 20 MHz clock, synchronous active-high reset, monitor inputs are async
// Notes: Pin-side inputs pass two flip-flops, the temperature code three; the stored configuration survives reset
// Summary of operation
// - Ready only after status lines driven low
// - Pin configuration latched only at power cycle
// - Three shutdown sources: command, pin, faults
// - Command shutdown stays active two seconds
// - Switch-off ends with reference low, message
// - Automatic shutdown uses same orderly sequence
// - Alert on temperature range change if critical, configured or in guard
// - Warning alerts always, or within guard
// - Critical alert shuts down five seconds later
// - Critical alerts presented unconditionally
// - Levels encoded as 2,1,0,-1,-2
// - Undervoltage warning near minimum supply
// - Persistent undervoltage repeats, then switches off
// - Supply warnings need no enabling
// - Overvoltage warning once per approach
// - Defer thermal shutdown in guard or call
// - Call within guard extends guard
// - Deferred: alerts continue, shutdown suppressed
// - On resume, out of range shuts immediately
// - Sleep only with idle ports, configured
// - Expect-ready gates sleep and discards data
// - Clear line signals wake and readiness
`default_nettype none
module pss_supervisor
  import pss_pkg::*;
#(
  parameter int unsigned GUARD_CYCLES = GUARD_CYC,
  parameter int unsigned CRIT_CYCLES = CRIT_DELAY_CYC,
  parameter int unsigned SHUT_CYCLES = SHUTDOWN_CYC,
  parameter int unsigned UV_GAP_CYCLES = UV_GAP_CYC
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Stored configuration and its write strobe
  input wire pss_cfg_t cfg_wr_data_i,
  input wire logic cfg_wr_i,
  // Firmware and host requests
  input wire logic fw_init_done_i,
  input wire logic power_down_command_i,
  input wire logic fast_shutdown_pin_i,
  input wire logic emergency_call_i,
  input wire logic port0_request_in_i,
  input wire logic sleep_config_i,
  input wire logic ports_idle_i,
  input wire logic usb_tx_pending_i,
  input wire logic host_ready_i,
  // Monitors
  input wire logic [2:0] board_temp_level_i,
  input wire logic undervoltage_near_i,
  input wire logic overvoltage_near_i,
  // Outputs
  output logic port0_clear_out_o,
  output logic port0_set_ready_o,
  output logic port0_ring_indicator_o,
  output logic ready_o,
  output logic io_reference_out_o,
  output pss_msg_t msg_o,
  output logic msg_valid_o,
  output logic sleep_o,
  output logic discard_tx_o,
  output pss_cfg_t active_cfg_o
);

  function automatic logic is_crit(input logic [2:0] lv);
    return (lv == TEMP_P2) || (lv == TEMP_M2);
  endfunction

  // Input synchronisers
  logic [1:0] s_fast, s_call, s_rts, s_uv, s_ov, s_idle, s_pend, s_hrdy;
  logic [2:0] s_t0, s_t1, s_t2, temp_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_fast <= 2'h3;
      s_rts <= 2'h3;
      {s_call, s_uv, s_ov, s_idle, s_pend, s_hrdy} <= 12'h000;
      s_t0 <= 3'h0;
      s_t1 <= 3'h0;
      s_t2 <= 3'h0;
      temp_q <= TEMP_Z0;
    end else if (clk_en_i) begin
      s_fast <= {s_fast[0], fast_shutdown_pin_i};
      s_call <= {s_call[0], emergency_call_i};
      s_rts <= {s_rts[0], port0_request_in_i};
      s_uv <= {s_uv[0], undervoltage_near_i};
      s_ov <= {s_ov[0], overvoltage_near_i};
      s_idle <= {s_idle[0], ports_idle_i};
      s_pend <= {s_pend[0], usb_tx_pending_i};
      s_hrdy <= {s_hrdy[0], host_ready_i};
      s_t0 <= board_temp_level_i;
      s_t1 <= s_t0;
      s_t2 <= s_t1;
      // A level counts only once two samples agree, so a torn code word never passes
      if (s_t1 == s_t2) temp_q <= s_t1;
    end
  end
  wire logic fast_n = s_fast[1];
  wire logic call = s_call[1];
  wire logic [2:0] temp = temp_q;

  // State of the supervisor
  pss_state_t state, next_state;
  // Stored copy starts at the defaults at power-up and is never cleared by reset
  pss_cfg_t nv_cfg = '{alert_always: TEMP_ALERT_PRES_RST[0], crit_sd_en: CRIT_SD_EN_RST,
                       expect_tr: EXPECT_TR_RST};
  pss_cfg_t act_cfg, next_nv_cfg, next_act_cfg;
  logic cfg_loaded, next_cfg_loaded;
  logic [31:0] guard_cnt, next_guard_cnt, crit_cnt, next_crit_cnt, shut_cnt, next_shut_cnt;
  logic [31:0] uv_cnt, next_uv_cnt;
  logic [2:0] uv_sent, next_uv_sent, last_temp, next_last_temp;
  logic crit_arm, next_crit_arm, ov_sent, next_ov_sent, rts_prev, next_rts_prev;
  logic clear_o, next_clear_o, dsr_o, next_dsr_o, ring_o, next_ring_o, ready, next_ready;
  logic vref, next_vref, mval, next_mval, sleep, next_sleep, disc, next_disc;
  pss_msg_t msg, next_msg;
  logic guard, deferred, crit_due, uv_due;

  // Next-state computation
  always_comb begin
    next_state = state;
    next_nv_cfg = nv_cfg;
    next_act_cfg = act_cfg;
    next_cfg_loaded = 1'h1;
    next_guard_cnt = guard_cnt;
    next_crit_cnt = crit_cnt;
    next_shut_cnt = shut_cnt;
    next_uv_cnt = uv_cnt;
    next_uv_sent = uv_sent;
    next_last_temp = temp;
    next_crit_arm = crit_arm;
    next_ov_sent = ov_sent;
    next_rts_prev = s_rts[1];
    next_clear_o = clear_o;
    next_dsr_o = dsr_o;
    next_ring_o = ring_o;
    next_ready = ready;
    next_vref = vref;
    next_mval = 1'h0;
    next_msg = msg;
    next_sleep = sleep;
    next_disc = 1'h0;
    // Stored value changes only the non-volatile copy
    if (cfg_wr_i) next_nv_cfg = cfg_wr_data_i;
    if (!cfg_loaded) next_act_cfg = nv_cfg;
    // Guard counted from reset release; a call running at its last cycle holds it open,
    // while a call started after expiry does not reopen it
    guard = guard_cnt < GUARD_CYCLES;
    if (guard_cnt < GUARD_CYCLES && !(call && guard_cnt == GUARD_CYCLES - 1)) begin
      next_guard_cnt = guard_cnt + 32'h1;
    end
    deferred = guard || call;
    crit_due = crit_arm && crit_cnt >= CRIT_CYCLES;
    uv_due = s_uv[1] && uv_cnt >= UV_GAP_CYCLES;
    unique case (state)
      PSS_INIT: begin
        next_clear_o = 1'h1;
        next_dsr_o = 1'h1;
        next_ring_o = 1'h1;
        if (fw_init_done_i) begin
          next_clear_o = 1'h0;
          next_dsr_o = 1'h0;
          next_ring_o = 1'h0;
          next_state = PSS_RUN;
        end
      end
      PSS_RUN: begin
        next_ready = !clear_o && !dsr_o && !ring_o;
        // Temperature alerts on code change only
        if (temp != last_temp) begin
          if (is_crit(temp) || act_cfg.alert_always || guard) begin
            next_mval = 1'h1;
            next_msg = '{kind: PSS_MSG_TEMP, level: temp};
          end
          if (is_crit(temp)) begin
            next_crit_arm = 1'h1;
            next_crit_cnt = 32'h0;
          end else begin
            next_crit_arm = 1'h0;
          end
        end else if (crit_arm && crit_cnt < CRIT_CYCLES) begin
          next_crit_cnt = crit_cnt + 32'h1;
        end
        // Supply warnings, always enabled
        if (s_ov[1] && !ov_sent && !next_mval) begin
          next_mval = 1'h1;
          next_msg = '{kind: PSS_MSG_OVERV, level: 3'h0};
          next_ov_sent = 1'h1;
        end else if (!s_ov[1]) begin
          next_ov_sent = 1'h0;
        end
        if (!s_uv[1]) begin
          next_uv_cnt = UV_GAP_CYCLES;
          next_uv_sent = 3'h0;
        end else if (uv_due && !next_mval) begin
          next_mval = 1'h1;
          next_msg = '{kind: PSS_MSG_UNDERV, level: 3'h0};
          next_uv_sent = uv_sent + 3'h1;
          next_uv_cnt = 32'h0;
        end else if (uv_cnt < UV_GAP_CYCLES) begin
          next_uv_cnt = uv_cnt + 32'h1;
        end
        // Sleep entry and wake on request falling edge
        next_disc = act_cfg.expect_tr && !s_hrdy[1] && s_pend[1];
        // Stays awake while the host holds its request active after a wake
        if (s_idle[1] && sleep_config_i && s_rts[1] && !(act_cfg.expect_tr && s_pend[1])) begin
          next_sleep = 1'h1;
        end
        if (sleep && rts_prev && !s_rts[1]) begin
          next_sleep = 1'h0;
          next_clear_o = 1'h0;
        end else if (sleep) begin
          next_clear_o = 1'h1;
        end else begin
          next_clear_o = 1'h0;
        end
        // Shutdown sources, all through the same orderly sequence
        if (power_down_command_i || !fast_n || (uv_sent >= UV_REPEAT[2:0] && uv_due) ||
            (crit_due && !deferred && act_cfg.crit_sd_en)) begin
          next_state = PSS_SHUT;
          next_shut_cnt = 32'h0;
          next_sleep = 1'h0;
          next_ready = 1'h0;
        end
      end
      PSS_SHUT: begin
        next_shut_cnt = shut_cnt + 32'h1;
        if (shut_cnt >= SHUT_CYCLES - 1) begin
          next_state = PSS_OFF;
          next_vref = 1'h0;
          next_mval = 1'h1;
          next_msg = '{kind: PSS_MSG_SHUTDOWN, level: 3'h0};
        end
      end
      PSS_OFF: begin
        next_vref = 1'h0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= PSS_INIT;
      // Stored copy is left alone: it must outlive the power cycle it configures
      act_cfg <= '{alert_always: TEMP_ALERT_PRES_RST[0], crit_sd_en: CRIT_SD_EN_RST,
                   expect_tr: EXPECT_TR_RST};
      cfg_loaded <= 1'h0;
      {guard_cnt, crit_cnt, shut_cnt, uv_cnt} <= 128'h0;
      uv_sent <= 3'h0;
      last_temp <= TEMP_Z0;
      {crit_arm, ov_sent, ready, mval, sleep, disc} <= 6'h00;
      rts_prev <= 1'h1;
      {clear_o, dsr_o, ring_o, vref} <= 4'hf;
      msg <= '{kind: PSS_MSG_NONE, level: 3'h0};
    end else if (clk_en_i) begin
      state <= next_state;
      nv_cfg <= next_nv_cfg;
      act_cfg <= next_act_cfg;
      cfg_loaded <= next_cfg_loaded;
      guard_cnt <= next_guard_cnt;
      crit_cnt <= next_crit_cnt;
      shut_cnt <= next_shut_cnt;
      uv_cnt <= next_uv_cnt;
      uv_sent <= next_uv_sent;
      last_temp <= next_last_temp;
      crit_arm <= next_crit_arm;
      ov_sent <= next_ov_sent;
      rts_prev <= next_rts_prev;
      clear_o <= next_clear_o;
      dsr_o <= next_dsr_o;
      ring_o <= next_ring_o;
      ready <= next_ready;
      vref <= next_vref;
      mval <= next_mval;
      msg <= next_msg;
      sleep <= next_sleep;
      disc <= next_disc;
    end
  end

  assign port0_clear_out_o = clear_o;
  assign port0_set_ready_o = dsr_o;
  assign port0_ring_indicator_o = ring_o;
  assign ready_o = ready;
  assign io_reference_out_o = vref;
  assign msg_o = msg;
  assign msg_valid_o = mval;
  assign sleep_o = sleep;
  assign discard_tx_o = disc;
  assign active_cfg_o = act_cfg;

  // Checks
  AST_READY_LINES: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ready |-> (!dsr_o && !ring_o)) else $error("ready with status lines high");
  AST_OFF_VREF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state == PSS_OFF) |-> !vref) else $error("reference high after switch-off");
  AST_SHUT_MSG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (clk_en_i && state == PSS_SHUT && next_state == PSS_OFF) |=> (mval &&
    msg.kind == PSS_MSG_SHUTDOWN)) else $error("no shutdown message");
  AST_PIN_SHUT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (clk_en_i && state == PSS_RUN && !fast_n) |=> state == PSS_SHUT)
    else $error("fast pin ignored");
  AST_DEFER: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (clk_en_i && state == PSS_RUN && call && !power_down_command_i && fast_n && !uv_due)
    |=> state != PSS_SHUT) else $error("shutdown during call");
  AST_CRIT_MSG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (clk_en_i && state == PSS_RUN && temp != last_temp && is_crit(temp)) |=>
    (mval && msg.level == $past(temp))) else $error("critical alert missing");
  AST_NO_WARN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (clk_en_i && state == PSS_RUN && !guard && !act_cfg.alert_always && !is_crit(temp))
    |=> !(mval && msg.kind == PSS_MSG_TEMP)) else $error("warning outside guard");
  AST_SLEEP_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (clk_en_i && !sleep && !s_idle[1]) |=> !sleep) else $error("sleep with busy port");
endmodule
`default_nettype wire

// ==== tb/pss_host_model.sv ====
// Purpose: Host side model: wakes the device and tallies its messages
// Assumes: Messages are sampled on the rising clock edge
// Notes: The request line idles high while the host leaves it inactive
`default_nettype none
module pss_host_model
  import pss_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Device messages and wake trigger
  input wire pss_msg_t msg_i,
  input wire logic msg_valid_i,
  input wire logic wake_i,
  // Wake line to the device
  output logic port0_request_in_o,
  // Message tallies by kind, last level seen
  output logic [7:0] cnt_o [8],
  output logic [2:0] last_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wake: request goes from inactive high to active low
  always_ff @(posedge clk_i) begin
    port0_request_in_o <= !wake_i;
  end
  // Count each message the device emits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_o <= '{default: 8'h00};
      last_level_o <= 3'h0;
    end else if (msg_valid_i) begin
      cnt_o[msg_i.kind] <= cnt_o[msg_i.kind] + 8'h01;
      last_level_o <= msg_i.level;
    end
  end
endmodule
`default_nettype wire

// ==== tb/pss_supervisor_bench.sv ====
// Purpose: Self-checking bench of the power and shutdown supervisor
// Assumes: Short timer parameters; counts in the host model
// Notes: Random warning levels and configuration from a fixed seed
`default_nettype none
module pss_supervisor_bench import pss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned GC = 100;
  localparam int unsigned CC = 60;
  localparam int unsigned SC = 50;
  localparam int unsigned UG = 50;
  logic clk_i = 1'b0;
  logic rst = 1'b1, cfg_wr = 1'b0, fw = 1'b0, pd = 1'b0, fast = 1'b1, ecall = 1'b0;
  logic slp_cfg = 1'b0, idle = 1'b0, usb = 1'b0, uv = 1'b0, ov = 1'b0, wake = 1'b0;
  logic en = 1'b1, hrdy = 1'b1;
  logic [2:0] temp = 3'h0;
  pss_cfg_t cfg_d = '0;
  logic clr, dsr, ring, rdy, vref, mv, slp, req, disc;
  pss_msg_t msg;
  pss_cfg_t act;
  logic [7:0] cnt [8];
  logic [2:0] lvl;
  int checked = 0;
  int fails = 0;
  logic [31:0] seed = 32'h4e2db800;
  // Device under test with short timers
  pss_supervisor #(.GUARD_CYCLES(GC), .CRIT_CYCLES(CC), .SHUT_CYCLES(SC),
    .UV_GAP_CYCLES(UG)) pss_supervisor_i (.clk_i(clk_i), .sys_rst_i(rst),
    .clk_en_i(en), .cfg_wr_data_i(cfg_d), .cfg_wr_i(cfg_wr), .fw_init_done_i(fw),
    .power_down_command_i(pd), .fast_shutdown_pin_i(fast), .emergency_call_i(ecall),
    .port0_request_in_i(req), .sleep_config_i(slp_cfg), .ports_idle_i(idle),
    .usb_tx_pending_i(usb), .host_ready_i(hrdy), .board_temp_level_i(temp),
    .undervoltage_near_i(uv), .overvoltage_near_i(ov), .port0_clear_out_o(clr),
    .port0_set_ready_o(dsr), .port0_ring_indicator_o(ring), .ready_o(rdy),
    .io_reference_out_o(vref), .msg_o(msg), .msg_valid_o(mv), .sleep_o(slp),
    .discard_tx_o(disc), .active_cfg_o(act));
  // Host at the far side
  pss_host_model pss_host_model_i (.clk_i(clk_i), .sys_rst_i(rst), .msg_i(msg),
    .msg_valid_i(mv), .wake_i(wake), .port0_request_in_o(req), .cnt_o(cnt),
    .last_level_o(lvl));
  // 20 MHz clock
  initial begin
    forever #25 clk_i = !clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Next warning level, always different from the current one
  function automatic logic [2:0] next_warn(input logic [2:0] cur, input logic [31:0] r);
    logic [2:0] opts [3] = '{TEMP_P1, TEMP_Z0, TEMP_M1};
    logic [2:0] v;
    v = opts[r % 3];
    return (v == cur) ? opts[(r + 1) % 3] : v;
  endfunction
  task automatic print_verdict();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] act_v);
    checked++;
    if (act_v !== exp) begin
      fails++;
      $display("[ERR] t=%0t exp=%h act=%h", $time, exp, act_v);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bounded wait until a message tally reaches a value
  task automatic wait_cnt(input int k, input logic [7:0] want, input int lim, output int n);
    n = 0;
    while (cnt[k] !== want && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (cnt[k] !== want) begin
      chk(want, cnt[k]);
      print_verdict();
    end
  endtask
  // Reset for 10 cycles, then finish firmware start
  task automatic boot();
    @(posedge clk_i);
    {rst, fw, pd, fast, ecall, uv, ov, wake, slp_cfg, idle, usb} <= 11'h480;
    temp <= TEMP_Z0;
    repeat (10) @(posedge clk_i);
    rst <= 1'b0;
    cyc(1);
    chk(8'h0f, {4'h0, clr, dsr, ring, vref});
    chk(8'h00, {7'h0, rdy});
    @(posedge clk_i);
    fw <= 1'b1;
    cyc(4);
    chk(8'h01, {4'h0, clr, dsr, ring, rdy});
  endtask
  initial begin
    int n;
    logic [7:0] c;
    boot();
    // Stored configuration waits for a power cycle
    chk(8'h03, {5'h0, act});
    seed = xs(seed);
    @(posedge clk_i);
    // Warnings always shown, critical shutdown off, random expect-ready bit
    cfg_d <= {2'h2, seed[0]};
    cfg_wr <= 1'b1;
    @(posedge clk_i);
    cfg_wr <= 1'b0;
    cyc(4);
    chk(8'h03, {5'h0, act});
    // Random warning levels inside the guard period
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      c = cnt[1];
      @(posedge clk_i);
      temp <= next_warn(temp, seed);
      wait_cnt(1, c + 8'h01, 10, n);
      chk({5'h0, temp}, {5'h0, lvl});
    end
    cyc(10);
    chk(c + 8'h01, cnt[1]);
    // Warnings dropped after the guard, critical always shown
    cyc(GC);
    c = cnt[1];
    @(posedge clk_i);
    temp <= (temp == TEMP_M1) ? TEMP_P1 : TEMP_M1;
    cyc(10);
    chk(c, cnt[1]);
    @(posedge clk_i);
    temp <= TEMP_M2;
    wait_cnt(1, c + 8'h01, 10, n);
    chk({5'h0, TEMP_M2}, {5'h0, lvl});
    wait_cnt(4, 8'h01, CC + SC + 20, n);
    chk(8'h01, {7'h0, n >= CC});
    chk(8'h00, {7'h0, vref});
    // Stored configuration in force after the power cycle
    boot();
    chk({5'h0, cfg_d}, {5'h0, act});
    cyc(GC);
    @(posedge clk_i);
    temp <= TEMP_P1;
    wait_cnt(1, 8'h01, 12, n);
    @(posedge clk_i);
    temp <= TEMP_P2;
    wait_cnt(1, 8'h02, 12, n);
    cyc(CC + 20);
    chk(8'h01, {7'h0, vref});
    chk(8'h00, cnt[4]);
    @(posedge clk_i);
    cfg_d <= 3'h3;
    cfg_wr <= 1'b1;
    @(posedge clk_i);
    cfg_wr <= 1'b0;
    // Overvoltage once per approach, sleep gating, wake, command
    boot();
    chk(8'h03, {5'h0, act});
    @(posedge clk_i);
    ov <= 1'b1;
    wait_cnt(3, 8'h01, 10, n);
    cyc(20);
    chk(8'h01, cnt[3]);
    @(posedge clk_i);
    {ov, slp_cfg, idle, usb, hrdy} <= 5'h0e;
    cyc(8);
    chk(8'h00, {7'h0, slp});
    chk(8'h01, {7'h0, disc});
    @(posedge clk_i);
    {ov, usb, hrdy} <= 3'h5;
    wait_cnt(3, 8'h02, 10, n);
    cyc(8);
    chk(8'h03, {5'h0, disc, slp, clr});
    @(posedge clk_i);
    wake <= 1'b1;
    cyc(8);
    chk(8'h00, {6'h0, slp, clr});
    @(posedge clk_i);
    pd <= 1'b1;
    @(posedge clk_i);
    pd <= 1'b0;
    wait_cnt(4, 8'h01, SC + 20, n);
    chk(8'h01, {7'h0, n >= SC - 2});
    chk(8'h00, {7'h0, vref});
    // Fast shutdown pin
    boot();
    @(posedge clk_i);
    fast <= 1'b0;
    en <= 1'b0;
    cyc(SC + 10);
    chk(8'h01, {7'h0, vref});
    @(posedge clk_i);
    en <= 1'b1;
    wait_cnt(4, 8'h01, SC + 20, n);
    chk(8'h00, {7'h0, vref});
    // Persistent undervoltage repeats, then switches off
    boot();
    @(posedge clk_i);
    uv <= 1'b1;
    wait_cnt(4, 8'h01, 6 * UG + SC + 40, n);
    chk(8'h05, cnt[2]);
    // Critical level deferred by an emergency call in the guard
    boot();
    @(posedge clk_i);
    ecall <= 1'b1;
    temp <= TEMP_M2;
    wait_cnt(1, 8'h01, 10, n);
    cyc(GC + CC + 20);
    chk(8'h01, {7'h0, vref});
    @(posedge clk_i);
    ecall <= 1'b0;
    wait_cnt(4, 8'h01, SC + 20, n);
    chk(8'h01, cnt[1]);
    print_verdict();
  end
endmodule
`default_nettype wire
